/* hw/pps_pkg.sv */
// constants, opcodes and register map of the positioning step controller
// What this block does
// RQ1: hold next step until pulse count exceeds operand
// RQ2: zero pulse-wait operand clears the pulse count
// RQ3: repeat enclosed steps operand times, then continue
// RQ4: programs never nest one repeat block inside another
// RQ5: leading run-count step repeats whole program
// RQ6: run-count operand zero means endless repetition
// RQ7: without run-count step, program runs once
// RQ8: armed capture stores position on input, readable
// RQ9: capture arming cancelled at program end
// RQ10: mode change, forced stop, alarm, servo off disarm
// RQ11: temporary stop keeps the capture arming
// RQ12: indirect operands allowed for listed commands only
// RQ13: indirect operand takes current register value
// RQ14: host writes registers only while program idle
// RQ15: register contents lost at power-off
// RQ16: eight registers can be saved to non-volatile memory
// RQ17: register range is the using command's range
// RQ18: position operands scaled by 1, 10, 100, 1000
// RQ19: first capture edge after arming only
// RQ20: pulse count accumulates until zero-wait or reset
package pps_pkg;
  localparam int PC_W = 8;
  localparam int OPND_W = 24;
  localparam int CMD_W = 34;
  localparam int GP_AW = 3;
  localparam logic [GP_AW-1:0] GP_LAST = 3'h7;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PULSE_COUNT = 8'h08;
  localparam logic [7:0] ADDR_CAPTURE_POS = 8'h0C;
  localparam logic [7:0] ADDR_RUN_LEFT = 8'h10;
  localparam logic [7:0] ADDR_LOOP_LEFT = 8'h14;
  localparam logic [2:0] GP_WINDOW = 3'h1;

  // control fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SAVE_BIT = 1;
  localparam int CTRL_SCALE_LSB = 2;
  localparam int CTRL_PC_LSB = 8;
  localparam logic [1:0] SCALE_RST = 2'h0;
  localparam logic [PC_W-1:0] START_PC_RST = 8'h00;
  localparam logic [OPND_W-1:0] RUN_ONCE = 24'h000001;

  // feed length factors
  localparam logic [10:0] SCALE_X1 = 11'h001;
  localparam logic [10:0] SCALE_X10 = 11'h00A;
  localparam logic [10:0] SCALE_X100 = 11'h064;
  localparam logic [10:0] SCALE_X1000 = 11'h3E8;

  // step word fields
  localparam int INS_OP_LSB = 28;
  localparam int INS_IND_BIT = 27;
  localparam int INS_REG_LSB = 24;

  // opcodes
  localparam logic [3:0] OP_SPEED_CMD = 4'h0;
  localparam logic [3:0] OP_ACCEL_TIME_CMD = 4'h1;
  localparam logic [3:0] OP_DECEL_TIME_CMD = 4'h2;
  localparam logic [3:0] OP_ACCEL_DECEL_TIME_CMD = 4'h3;
  localparam logic [3:0] OP_S_CURVE_TIME_CMD = 4'h4;
  localparam logic [3:0] OP_ABSOLUTE_MOVE_CMD = 4'h5;
  localparam logic [3:0] OP_INCREMENTAL_MOVE_CMD = 4'h6;
  localparam logic [3:0] OP_ABSOLUTE_CONTINUOUS_MOVE_CMD = 4'h7;
  localparam logic [3:0] OP_INCREMENTAL_CONTINUOUS_MOVE_CMD = 4'h8;
  localparam logic [3:0] OP_DWELL_CMD = 4'h9;
  localparam logic [3:0] OP_RUN_COUNT_CMD = 4'hA;
  localparam logic [3:0] OP_PULSE_WAIT_CMD = 4'hB;
  localparam logic [3:0] OP_REPEAT_OPEN_CMD = 4'hC;
  localparam logic [3:0] OP_REPEAT_CLOSE_CMD = 4'hD;
  localparam logic [3:0] OP_POSITION_CAPTURE_CMD = 4'hE;
  localparam logic [3:0] OP_PROGRAM_END_CMD = 4'hF;

  typedef enum logic [2:0] {
    PPS_IDLE,
    PPS_FETCH,
    PPS_DECODE,
    PPS_OPERAND,
    PPS_EXEC,
    PPS_MOTION,
    PPS_PULSE_WAIT
  } pps_state_e;
endpackage : pps_pkg

/* hw/pps_gpreg.sv */
// eight general-purpose operand registers, two registered read ports
`timescale 1ns/1ps
module pps_gpreg (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // write port
  input wire logic we,
  input wire logic [pps_pkg::GP_AW-1:0] waddr,
  input wire logic [31:0] wdata,
  // read ports
  input wire logic [pps_pkg::GP_AW-1:0] raddr_a,
  output logic [31:0] rdata_a,
  input wire logic [pps_pkg::GP_AW-1:0] raddr_b,
  output logic [31:0] rdata_b
);
  import pps_pkg::*;

  logic [31:0] mem [8];

  genvar g;
  for (g = 0; g < 8; g++) begin : g_ent
    // no backing store: contents are zero after every power-up
    always_ff @(posedge mclk) begin
      if (sys_rst) begin
        mem[g] <= 32'h0; // RQ15
      end else if (we && waddr == 3'(g)) begin
        mem[g] <= wdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_a <= 32'h0;
      rdata_b <= 32'h0;
    end else begin
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
    end
  end
endmodule : pps_gpreg

/* hw/pps_capture.sv */
// current position latch armed by the capture step
`timescale 1ns/1ps
module pps_capture (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // control
  input wire logic arm,
  input wire logic disarm,
  // sampled inputs
  input wire logic capture_input,
  input wire logic [31:0] cur_position,
  // state
  output logic armed,
  output logic cap_valid,
  output logic [31:0] cap_pos
);
  import pps_pkg::*;

  logic prev_in;
  logic rise;

  assign rise = capture_input && !prev_in;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prev_in <= 1'b0;
      armed <= 1'b0;
      cap_valid <= 1'b0;
      cap_pos <= 32'h0;
    end else begin
      prev_in <= capture_input;
      if (armed && rise) begin
        cap_pos <= cur_position; // RQ8
      end
      // a capture that lands with a disarm is still kept
      if (armed && rise) begin
        cap_valid <= 1'b1; // RQ8
      end else if (arm) begin
        cap_valid <= 1'b0;
      end
      if (arm) begin
        armed <= 1'b1;
      end else if (disarm || (armed && rise)) begin
        armed <= 1'b0; // RQ19
      end
    end
  end
endmodule : pps_capture

/* hw/pps_step_ctrl.sv */
// step controller of the positioning program interpreter, APB slave
`timescale 1ns/1ps
module pps_step_ctrl (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // program store
  output logic [pps_pkg::PC_W-1:0] prog_addr,
  input wire logic [31:0] prog_data,
  // motion executor
  output logic cmd_valid,
  output logic [3:0] cmd_code,
  output logic [pps_pkg::CMD_W-1:0] cmd_value,
  input wire logic cmd_done,
  // machine inputs
  input wire logic mpg_pulse,
  input wire logic capture_input,
  input wire logic [31:0] cur_position,
  input wire logic mode_change,
  input wire logic forced_stop,
  input wire logic alarm,
  input wire logic servo_off,
  input wire logic temp_stop,
  // status
  output logic running,
  output logic program_end,
  // non-volatile save
  output logic nv_wr,
  output logic [pps_pkg::GP_AW-1:0] nv_addr,
  output logic [31:0] nv_data
);
  import pps_pkg::*;

  pps_state_e state;
  logic [PC_W-1:0] pc;
  logic [PC_W-1:0] base_pc;
  logic [PC_W-1:0] loop_pc;
  logic [OPND_W-1:0] loop_left;
  logic [OPND_W-1:0] run_left;
  logic endless;
  logic first_pass;
  logic [3:0] ins_op;
  logic [OPND_W-1:0] ins_val;
  logic use_ind;
  logic [31:0] cnt_target;
  logic [31:0] pulse_count;

  logic [1:0] feed_scale_factor;
  logic [PC_W-1:0] start_pc;
  logic start_req;
  logic save_req;
  logic saving;
  logic [GP_AW-1:0] gp_raddr;
  logic sv_pipe;
  logic [GP_AW-1:0] sv_idx;
  logic arm_pulse;
  logic [31:0] gp_rd_a;
  logic [31:0] gp_rd_b;
  logic cap_armed;
  logic cap_valid;
  logic [31:0] cap_pos;

  logic abort;
  logic go;
  logic exec;
  logic is_motion;
  logic is_position;
  logic ind_ok_n;
  logic [OPND_W-1:0] opnd;
  logic [10:0] factor;
  logic pulse_clear;

  logic acc;
  logic wr_take;
  logic is_gp;
  logic gp_we;
  logic [31:0] rd_mux;
  logic err_n;

  // ---- decode helpers
  assign abort = mode_change || forced_stop || alarm || servo_off;
  assign go = !abort && !temp_stop; // RQ11
  assign exec = (state == PPS_EXEC) && go;
  assign is_motion = ins_op <= OP_DWELL_CMD;
  assign is_position = (ins_op >= OP_ABSOLUTE_MOVE_CMD) &&
                       (ins_op <= OP_INCREMENTAL_CONTINUOUS_MOVE_CMD);
  // only set-value commands may take a register; other steps ignore the flag
  assign ind_ok_n = prog_data[INS_IND_BIT] &&
                    (prog_data[INS_OP_LSB +: 4] <= OP_RUN_COUNT_CMD); // RQ12
  // register value is passed on unchecked; its range is the user's step's range
  assign opnd = use_ind ? gp_rd_b[OPND_W-1:0] : ins_val; // RQ13 RQ17
  assign pulse_clear = exec && (ins_op == OP_PULSE_WAIT_CMD) && (opnd == '0);

  always_comb begin
    case (feed_scale_factor)
      2'h0: factor = SCALE_X1;
      2'h1: factor = SCALE_X10;
      2'h2: factor = SCALE_X100;
      default: factor = SCALE_X1000;
    endcase
  end

  // ---- step sequencer
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state <= PPS_IDLE;
      pc <= START_PC_RST;
      base_pc <= START_PC_RST;
      loop_pc <= START_PC_RST;
      loop_left <= '0;
      run_left <= RUN_ONCE;
      endless <= 1'b0;
      first_pass <= 1'b0;
      ins_op <= OP_PROGRAM_END_CMD;
      ins_val <= '0;
      use_ind <= 1'b0;
      cnt_target <= 32'h0;
      running <= 1'b0;
      program_end <= 1'b0;
    end else begin
      program_end <= 1'b0;
      if (abort) begin
        state <= PPS_IDLE; // RQ10
        running <= 1'b0;
      end else if (!temp_stop || state == PPS_IDLE) begin
        case (state)
          PPS_IDLE: begin
            if (start_req && !saving) begin
              pc <= start_pc;
              base_pc <= start_pc;
              run_left <= RUN_ONCE; // RQ7
              endless <= 1'b0;
              first_pass <= 1'b1;
              loop_left <= '0;
              running <= 1'b1;
              state <= PPS_FETCH;
            end
          end
          PPS_FETCH: state <= PPS_DECODE;
          PPS_DECODE: begin
            ins_op <= prog_data[INS_OP_LSB +: 4];
            ins_val <= prog_data[OPND_W-1:0];
            use_ind <= ind_ok_n;
            state <= ind_ok_n ? PPS_OPERAND : PPS_EXEC;
          end
          PPS_OPERAND: state <= PPS_EXEC;
          PPS_EXEC: begin
            state <= PPS_FETCH;
            pc <= pc + 1'b1;
            case (ins_op)
              OP_RUN_COUNT_CMD: begin
                // only honoured as the first step of the first pass
                if (first_pass && pc == base_pc) begin
                  run_left <= opnd; // RQ5
                  endless <= (opnd == '0); // RQ6
                end
              end
              OP_PULSE_WAIT_CMD: begin
                if (opnd != '0) begin
                  cnt_target <= 32'(opnd);
                  pc <= pc;
                  state <= PPS_PULSE_WAIT; // RQ1
                end
              end
              OP_REPEAT_OPEN_CMD: begin
                // a count of zero still runs the body once
                loop_left <= (opnd == '0) ? RUN_ONCE : opnd; // RQ3
                loop_pc <= pc + 1'b1;
              end
              OP_REPEAT_CLOSE_CMD: begin
                // a single loop register serves: blocks never nest
                if (loop_left > RUN_ONCE) begin
                  loop_left <= loop_left - 1'b1; // RQ3 RQ4
                  pc <= loop_pc;
                end
              end
              OP_PROGRAM_END_CMD: begin
                program_end <= 1'b1;
                first_pass <= 1'b0;
                loop_left <= '0;
                if (endless || run_left > RUN_ONCE) begin
                  if (!endless) begin
                    run_left <= run_left - 1'b1; // RQ5
                  end
                  pc <= base_pc; // RQ6
                end else begin
                  pc <= pc;
                  running <= 1'b0;
                  state <= PPS_IDLE;
                end
              end
              default: begin
                if (is_motion) begin
                  pc <= pc;
                  state <= PPS_MOTION;
                end
              end
            endcase
          end
          PPS_MOTION: begin
            if (cmd_done) begin
              pc <= pc + 1'b1;
              state <= PPS_FETCH;
            end
          end
          PPS_PULSE_WAIT: begin
            if (pulse_count > cnt_target) begin
              pc <= pc + 1'b1; // RQ1
              state <= PPS_FETCH;
            end
          end
          default: state <= PPS_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prog_addr <= START_PC_RST;
    end else begin
      prog_addr <= pc;
    end
  end

  // ---- motion command issue
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmd_valid <= 1'b0;
      cmd_code <= OP_SPEED_CMD;
      cmd_value <= '0;
    end else begin
      cmd_valid <= exec && is_motion;
      if (exec && is_motion) begin
        cmd_code <= ins_op;
        if (is_position) begin
          cmd_value <= CMD_W'($signed(opnd) * $signed({1'b0, factor})); // RQ18
        end else begin
          cmd_value <= CMD_W'($signed(opnd));
        end
      end
    end
  end

  // ---- manual pulse accumulator; a pulse in the clearing cycle is kept
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pulse_count <= 32'h0; // RQ20
    end else if (mpg_pulse) begin
      pulse_count <= pulse_clear ? 32'h1 : pulse_count + 1'b1; // RQ20
    end else if (pulse_clear) begin
      pulse_count <= 32'h0; // RQ2
    end
  end

  // ---- capture arming
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      arm_pulse <= 1'b0;
    end else begin
      arm_pulse <= exec && (ins_op == OP_POSITION_CAPTURE_CMD); // RQ8
    end
  end

  pps_capture u_capture (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .arm(arm_pulse),
    .disarm(program_end || abort), // RQ9 RQ10
    .capture_input(capture_input),
    .cur_position(cur_position),
    .armed(cap_armed),
    .cap_valid(cap_valid),
    .cap_pos(cap_pos)
  );

  // ---- apb slave: one wait state, answer in the second access cycle
  assign acc = psel && penable;
  assign wr_take = acc && pready && pwrite;
  assign is_gp = (paddr[7:5] == GP_WINDOW) && (paddr[1:0] == 2'h0);
  assign gp_we = wr_take && is_gp && !running; // RQ14

  always_comb begin
    rd_mux = 32'h0;
    err_n = 1'b0;
    if (is_gp) begin
      rd_mux = gp_rd_a;
      err_n = pwrite && running; // RQ14
    end else begin
      case (paddr)
        ADDR_CTRL: begin
          rd_mux[CTRL_SCALE_LSB +: 2] = feed_scale_factor;
          rd_mux[CTRL_PC_LSB +: PC_W] = start_pc;
        end
        ADDR_STATUS: begin
          rd_mux[5:0] = {endless, saving, state == PPS_PULSE_WAIT,
                         cap_valid, cap_armed, running};
          rd_mux[CTRL_PC_LSB +: PC_W] = pc;
        end
        ADDR_PULSE_COUNT: rd_mux = pulse_count;
        ADDR_CAPTURE_POS: rd_mux = cap_pos; // RQ8
        ADDR_RUN_LEFT: rd_mux = 32'(run_left);
        ADDR_LOOP_LEFT: rd_mux = 32'(loop_left);
        default: err_n = 1'b1;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc && !pready;
      if (acc && !pready) begin
        prdata <= pwrite ? 32'h0 : rd_mux;
        pslverr <= err_n;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      feed_scale_factor <= SCALE_RST;
      start_pc <= START_PC_RST;
      start_req <= 1'b0;
      save_req <= 1'b0;
    end else begin
      start_req <= wr_take && paddr == ADDR_CTRL && pwdata[CTRL_START_BIT];
      save_req <= wr_take && paddr == ADDR_CTRL && pwdata[CTRL_SAVE_BIT];
      if (wr_take && paddr == ADDR_CTRL) begin
        feed_scale_factor <= pwdata[CTRL_SCALE_LSB +: 2];
        start_pc <= pwdata[CTRL_PC_LSB +: PC_W];
      end
    end
  end

  // ---- operand read port, shared with the non-volatile save stream
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      saving <= 1'b0;
      gp_raddr <= '0;
      sv_pipe <= 1'b0;
      sv_idx <= '0;
      nv_wr <= 1'b0;
      nv_addr <= '0;
      nv_data <= 32'h0;
    end else begin
      sv_pipe <= saving;
      sv_idx <= gp_raddr;
      nv_wr <= sv_pipe; // RQ16
      nv_addr <= sv_idx;
      if (sv_pipe) begin
        nv_data <= gp_rd_b;
      end
      if (saving) begin
        gp_raddr <= gp_raddr + 1'b1;
        if (gp_raddr == GP_LAST) begin
          saving <= 1'b0;
        end
      end else if (save_req && state == PPS_IDLE) begin
        saving <= 1'b1; // RQ16
        gp_raddr <= '0;
      end else if (state == PPS_DECODE) begin
        gp_raddr <= prog_data[INS_REG_LSB +: GP_AW]; // RQ13
      end
    end
  end

  pps_gpreg u_gpreg (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .we(gp_we),
    .waddr(paddr[4:2]),
    .wdata(pwdata),
    .raddr_a(paddr[4:2]),
    .rdata_a(gp_rd_a),
    .raddr_b(gp_raddr),
    .rdata_b(gp_rd_b)
  );
endmodule : pps_step_ctrl

/* verification/pps_step_ctrl_assertions.sv */
// port-level assertions of the step controller, bound into its top
`timescale 1ns/1ps
module pps_step_ctrl_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // sequencer and machine inputs
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic running,
  input wire logic mode_change,
  input wire logic forced_stop,
  input wire logic alarm,
  input wire logic servo_off,
  // save stream
  input wire logic nv_wr,
  input wire logic [pps_pkg::GP_AW-1:0] nv_addr
);
  import pps_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic gp_sel;
  logic bad_sel;
  logic abort;
  assign gp_sel = paddr >= 8'h20 && paddr <= 8'h3C;
  assign bad_sel = (paddr >= 8'h18 && paddr < 8'h20) || paddr > 8'h3C;
  assign abort = mode_change || forced_stop || alarm || servo_off;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_nv_burst;
    nv_wr [*8] ##1 !nv_wr;
  endsequence
  property p_apb_wait;
    s_setup |=> !pready ##1 pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready not in second access cycle");
  property p_apb_pulse;
    pready |=> !pready;
  endproperty
  a_apb_pulse: assert property (p_apb_pulse) else $error("pready longer than one cycle");
  property p_unmapped;
    pready && bad_sel |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_gp_refuse;
    pready && pwrite && gp_sel && running && $past(running) && $past(running, 2) |-> pslverr;
  endproperty
  a_gp_refuse: assert property (p_gp_refuse) else $error("register write while running");
  property p_cmd_pulse;
    cmd_valid |=> !cmd_valid [*3];
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("motion issue too close");
  property p_cmd_code;
    cmd_valid |-> cmd_code <= OP_DWELL_CMD && $past(running);
  endproperty
  a_cmd_code: assert property (p_cmd_code) else $error("bad issue code or idle issue");
  property p_abort;
    abort |-> ##[1:2] !running;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not stop program");
  property p_nv_start;
    $rose(nv_wr) |-> nv_addr == 3'h0 ##0 s_nv_burst;
  endproperty
  a_nv_start: assert property (p_nv_start) else $error("save stream not eight words");
  property p_nv_step;
    nv_wr && $past(nv_wr) |-> nv_addr == $past(nv_addr) + 3'h1;
  endproperty
  a_nv_step: assert property (p_nv_step) else $error("save address not consecutive");
endmodule : pps_step_ctrl_checker

bind pps_step_ctrl pps_step_ctrl_checker i_pps_step_ctrl_checker (.*);

/* verification/pps_far_model.sv */
// program store and motion executor on the far side of the step controller
`timescale 1ns/1ps
module pps_far_model (
  // clock
  input wire logic mclk,
  // program store
  input wire logic [pps_pkg::PC_W-1:0] prog_addr,
  output logic [31:0] prog_data,
  // motion executor
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [pps_pkg::CMD_W-1:0] cmd_value,
  output logic cmd_done,
  input wire logic [7:0] done_lat,
  // status and save stream
  input wire logic program_end,
  input wire logic nv_wr,
  input wire logic [pps_pkg::GP_AW-1:0] nv_addr,
  input wire logic [31:0] nv_data
);
  import pps_pkg::*;
  // unused steps read as program end so a stray fetch cannot run away
  logic [31:0] rom [256] = '{default: {OP_PROGRAM_END_CMD, 28'h0}};
  logic [31:0] nvm [8];
  logic [3:0] last_code;
  logic [CMD_W-1:0] last_value;
  int n_cmd = 0;
  int n_end = 0;
  int wait_left = 0;
  // the step address is already a cycle late, so the store answers without latency
  assign prog_data = rom[prog_addr];
  // done comes done_lat + 1 cycles after cmd_valid, slow enough to be overtaken
  always @(posedge mclk) begin
    cmd_done <= wait_left == 1;
    if (cmd_valid) begin
      n_cmd <= n_cmd + 1;
      last_code <= cmd_code;
      last_value <= cmd_value;
      wait_left <= done_lat;
    end else if (wait_left != 0) begin
      wait_left <= wait_left - 1;
    end
    if (program_end) begin
      n_end <= n_end + 1;
    end
    if (nv_wr) begin
      nvm[nv_addr] <= nv_data;
    end
  end
endmodule : pps_far_model

/* verification/pps_step_ctrl_tb.sv */
// self-checking bench for the positioning step controller
`timescale 1ns/1ps
module pps_step_ctrl_tb;
  import pps_pkg::*;
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, cmd_valid, cmd_done, e;
  logic mpg_pulse, capture_input, temp_stop, running, program_end, nv_wr;
  logic [3:0] abort_in, cmd_code;
  logic [7:0] paddr, done_lat;
  logic [PC_W-1:0] prog_addr;
  logic [31:0] pwdata, prdata, prog_data, cur_position, nv_data, q;
  logic [CMD_W-1:0] cmd_value;
  logic [GP_AW-1:0] nv_addr;
  logic [10:0] sf [4] = '{SCALE_X1, SCALE_X10, SCALE_X100, SCALE_X1000};
  int fail_count = 0;
  int n_tests = 0;
  int c0, e0;
  pps_step_ctrl i_pps_step_ctrl (.*, .mode_change(abort_in[0]), .forced_stop(abort_in[1]),
    .alarm(abort_in[2]), .servo_off(abort_in[3]));
  pps_far_model i_pps_far_model (.*);
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic conclude();
    $display("mismatches %0d of %0d comparisons", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string name, input logic [33:0] exp, input logic [33:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic ld(input int a, input logic [3:0] op, input logic [3:0] ir, input int v);
    i_pps_far_model.rom[a] = {op, ir, 24'(v)};
  endtask : ld
  task automatic start(input logic [7:0] pc, input logic [1:0] sc);
    c0 = i_pps_far_model.n_cmd;
    e0 = i_pps_far_model.n_end;
    apb(1'b1, ADDR_CTRL, {16'h0000, pc, 4'h0, sc, 2'h1});
    tick(4);
  endtask : start
  task automatic idle();
    int n;
    n = 0;
    while (running !== 1'b0 && n < 5000) begin
      tick(1);
      n++;
    end
    if (n >= 5000) fail_count++;
    tick(2);
  endtask : idle
  task automatic pulse(input int n);
    repeat (n) begin
      mpg_pulse <= 1'b1;
      tick(1);
      mpg_pulse <= 1'b0;
      tick(1);
    end
  endtask : pulse
  initial begin
    #300us;
    fail_count++;
    conclude();
  end
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite, mpg_pulse, capture_input, temp_stop} = 6'h00;
    {paddr, pwdata, cur_position, abort_in} = 76'h0;
    done_lat = 8'h03;
    // every program keeps its repeat blocks flat
    ld(0, OP_INCREMENTAL_MOVE_CMD, 4'h8, 0);
    ld(4, OP_ABSOLUTE_MOVE_CMD, 4'h0, 7);
    ld(8, OP_REPEAT_OPEN_CMD, 4'h0, 3);
    ld(9, OP_DWELL_CMD, 4'h0, 5);
    ld(10, OP_REPEAT_CLOSE_CMD, 4'h0, 0);
    ld(16, OP_RUN_COUNT_CMD, 4'h0, 2);
    ld(17, OP_DWELL_CMD, 4'h0, 1);
    ld(20, OP_RUN_COUNT_CMD, 4'h0, 0);
    ld(21, OP_DWELL_CMD, 4'h0, 1);
    ld(24, OP_PULSE_WAIT_CMD, 4'h0, 0);
    ld(25, OP_PULSE_WAIT_CMD, 4'h0, 5);
    ld(26, OP_DWELL_CMD, 4'h0, 9);
    ld(32, OP_POSITION_CAPTURE_CMD, 4'h0, 0);
    ld(33, OP_DWELL_CMD, 4'h0, 2);
    tick(12);
    sys_rst <= 1'b0;
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status rst", 34'h0, q);
    apb(1'b0, 8'h3C, 32'h0);
    chk("gp rst", 34'h0, q);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped err", 34'h1, e);
    chk("unmapped data", 34'h0, q);
    for (int i = 0; i < 8; i++) apb(1'b1, 8'(32'h20 + 4 * i), 32'(32'h100 + 3 * i));
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 8'(32'h20 + 4 * i), 32'h0);
      chk("gp readback", 34'(32'h100 + 3 * i), q);
    end
    start(8'h00, 2'h1);
    idle();
    chk("indirect move", 34'd2560, i_pps_far_model.last_value);
    for (int s = 0; s < 4; s++) begin
      start(8'h04, 2'(s));
      idle();
      chk("scaled move", 34'(7 * sf[s]), i_pps_far_model.last_value);
      chk("move code", 34'(OP_ABSOLUTE_MOVE_CMD), i_pps_far_model.last_code);
      chk("single pass", 34'h1, i_pps_far_model.n_cmd - c0);
    end
    start(8'h08, 2'h0);
    idle();
    chk("repeat steps", 34'h3, i_pps_far_model.n_cmd - c0);
    chk("repeat then end", 34'h1, i_pps_far_model.n_end - e0);
    start(8'h10, 2'h0);
    idle();
    chk("run count steps", 34'h2, i_pps_far_model.n_cmd - c0);
    chk("run count passes", 34'h2, i_pps_far_model.n_end - e0);
    start(8'h14, 2'h0);
    tick(150);
    chk("endless", 34'h1, i_pps_far_model.n_cmd - c0 > 5);
    abort_in <= 4'h2;
    tick(1);
    abort_in <= 4'h0;
    tick(3);
    chk("forced stop", 34'h0, running);
    tick(10);
    pulse(3);
    apb(1'b0, ADDR_PULSE_COUNT, 32'h0);
    chk("count idle", 34'h3, q);
    start(8'h18, 2'h0);
    apb(1'b0, ADDR_PULSE_COUNT, 32'h0);
    chk("count cleared", 34'h0, q);
    pulse(5);
    tick(10);
    chk("wait holds", 34'h0, i_pps_far_model.n_cmd - c0);
    pulse(1);
    idle();
    chk("wait passes", 34'h1, i_pps_far_model.n_cmd - c0);
    apb(1'b0, ADDR_PULSE_COUNT, 32'h0);
    chk("count kept", 34'h6, q);
    done_lat <= 8'd60;
    start(8'h20, 2'h0);
    tick(10);
    cur_position <= 32'h00001234;
    capture_input <= 1'b1;
    tick(2);
    capture_input <= 1'b0;
    cur_position <= 32'h00005678;
    tick(2);
    capture_input <= 1'b1;
    tick(2);
    capture_input <= 1'b0;
    apb(1'b1, 8'h2C, 32'h0000DEAD);
    chk("gp write refused", 34'h1, e);
    idle();
    apb(1'b0, ADDR_CAPTURE_POS, 32'h0);
    chk("captured", 34'h1234, q);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("end disarms", 34'h2, q[2:1]);
    apb(1'b0, 8'h2C, 32'h0);
    chk("gp unchanged", 34'h109, q);
    start(8'h20, 2'h0);
    idle();
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("end disarms unfired", 34'h0, q[1]);
    for (int k = 0; k < 4; k++) begin
      start(8'h20, 2'h0);
      tick(8);
      if (k == 0) begin
        temp_stop <= 1'b1;
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("pause keeps arm", 34'h1, q[1]);
        temp_stop <= 1'b0;
      end
      abort_in <= 4'(1 << k);
      tick(1);
      abort_in <= 4'h0;
      tick(3);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("abort disarms", 34'h0, q[1:0]);
      tick(70);
    end
    apb(1'b1, ADDR_CTRL, 32'h00000002);
    tick(20);
    for (int i = 0; i < 8; i++) begin
      chk("saved word", 34'(32'h100 + 3 * i), i_pps_far_model.nvm[i]);
    end
    conclude();
  end
endmodule : pps_step_ctrl_tb
